// [design/cscr_pkg.sv]
/*
 * Shared constants for the core status and core control register pair:
 * register offsets, field positions and reset values.
 * Assumes a plain word-wide register port driven by the core's bus logic.
 */
package cscr_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] CSCR_STATUS_OFS  = 4'h0;
    localparam logic [3:0] CSCR_CONTROL_OFS = 4'h1;
    localparam int         CSCR_AW          = 4;
    localparam int         CSCR_DW          = 16;

    // Status field positions.
    localparam int ST_OA   = 15;
    localparam int ST_OB   = 14;
    localparam int ST_SA   = 13;
    localparam int ST_SB   = 12;
    localparam int ST_OAB  = 11;
    localparam int ST_SAB  = 10;
    localparam int ST_LOOP = 9;
    localparam int ST_HC   = 8;
    localparam int ST_PRH  = 7;
    localparam int ST_PRL  = 5;
    localparam int ST_RPT  = 4;
    localparam int ST_NEG  = 3;
    localparam int ST_OV   = 2;
    localparam int ST_Z    = 1;
    localparam int ST_C    = 0;

    // Control field positions.
    localparam int CC_US   = 12;
    localparam int CC_EDT  = 11;
    localparam int CC_DLH  = 10;
    localparam int CC_DLL  = 8;
    localparam int CC_ACC_A_CLIP_ENABLE = 7;
    localparam int CC_ACC_B_CLIP_ENABLE = 6;
    localparam int CC_SDW  = 5;
    localparam int CC_WIDE = 4;
    localparam int CC_PRT  = 3;
    localparam int CC_PSV  = 2;
    localparam int CC_RND  = 1;
    localparam int CC_IMUL = 0;

    // Reset values of the software-held fields, and the low priority code that disables user interrupts.
    localparam logic [2:0] CSCR_PRIO_RST   = 3'h0;
    localparam logic [6:0] CSCR_CTRL_RST   = 7'h10; // ACC_A_CLIP_ENABLE,ACC_B_CLIP_ENABLE,SDW,WIDE,PROGRAM_WINDOW_ENABLE,RND,IMUL: store clip on.
    localparam logic [2:0] CSCR_PRIO_MAX   = 3'h7;
endpackage

// [design/cscr_regs.sv]
/*
 * Core status and core control register pair of a 16-bit DSP core.
 * Holds the datapath flags, the DSP mode settings and the priority level,
 * and exposes them to software over a plain address/strobe register port.
 * Assumes the datapath and sequencer present flag updates synchronously to
 * i_ref_clk and sample the exported modes in the same cycle they are used.
 */
// Behaviour
// - Guard overflow bits follow accumulator overflow.
// - Saturation bits stick until cleared.
// - Software may only clear sticky saturation bits.
// - Clearing combined sticky clears both sticky bits.
// - Combined overflow is OR of both.
// - Combined sticky is OR of both.
// - Loop-active bit shows DO loop running.
// - Half carry from bit 3 or 7.
// - Priority is top bit over low bits.
// - Code 111 disables user interrupts.
// - Low priority bits locked when nesting disabled.
// - Repeat-active bit shows REPEAT running.
// - Negative flag follows result sign.
// - Signed wrap flag marks sign overflow.
// - Zero flag clears on non-zero only.
// - Carry from MSB, inverted borrow subtracting.
// - Unsigned and integer multiply selects.
// - Early exit pulses, always reads zero.
// - Loop depth reports active DO loops.
// - Saturation enables; store enable resets one.
// - Wide clip mode selects super saturation.
// - Program window and rounding selects.
module cscr_regs
    import cscr_pkg::*;
(
    // Clock and reset.
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst_b,
    // Register port.
    input  wire logic [cscr_pkg::CSCR_AW-1:0] i_reg_addr,
    input  wire logic [cscr_pkg::CSCR_DW-1:0] i_reg_wdata,
    input  wire logic                         i_reg_wr,
    input  wire logic                         i_reg_rd,
    output logic      [cscr_pkg::CSCR_DW-1:0] o_reg_rdata,
    // Accumulator events from the DSP engine.
    input  wire logic                         i_acc_upd_a,
    input  wire logic                         i_acc_upd_b,
    input  wire logic                         i_acc_ovf_a,
    input  wire logic                         i_acc_ovf_b,
    input  wire logic                         i_acc_sat_a,
    input  wire logic                         i_acc_sat_b,
    // Sequencer state.
    input  wire logic                         i_do_active,
    input  wire logic                         i_rpt_active,
    input  wire logic [2:0]                   i_do_depth,
    input  wire logic                         i_nesting_disable,
    input  wire logic                         i_prio_wr,
    input  wire logic [3:0]                   i_prio_level,
    // ALU flag results.
    input  wire logic                         i_alu_upd,
    input  wire logic                         i_alu_byte,
    input  wire logic                         i_alu_sub,
    input  wire logic [15:0]                  i_alu_a,
    input  wire logic [15:0]                  i_alu_b,
    // Mode outputs to the datapath.
    output logic                              o_dsp_mul_unsigned,
    output logic                              o_integer_mul_mode,
    output logic                              o_early_loop_exit,
    output logic                              o_acc_a_clip_enable,
    output logic                              o_acc_b_clip_enable,
    output logic                              o_store_clip_enable,
    output logic                              o_wide_clip_mode,
    output logic                              o_program_window_enable,
    output logic                              o_rounding_select,
    output logic      [3:0]                   o_cpu_priority,
    output logic                              o_user_irq_disable
);
    import cscr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage.
    logic        ovf_a_reg, ovf_b_reg;          // Guard overflow flags.
    logic        sat_a_reg, sat_b_reg;          // Sticky saturation flags.
    logic        hc_reg, neg_reg, ov_reg;       // ALU flags.
    logic        z_reg, c_reg;                  // ALU zero and carry.
    logic [2:0]  prio_lo_reg;                   // Low priority bits.
    logic        prio_top_reg;                  // Top priority bit.
    logic [6:0]  mode_reg;                      // Control bits 7..4 and 2..0 packed.
    logic        edt_reg;                       // Early exit pulse.
    logic        loop_reg, rpt_reg;             // Registered sequencer state.
    logic [2:0]  depth_reg;                     // Registered loop depth.
    logic [15:0] rdata_reg;                     // Read data register.
    logic        us_reg;                        // Unsigned multiply select, bit 12.

    logic        wr_st, wr_cc;                  // Decoded writes.
    logic [16:0] sum;                           // ALU sum with carry out.
    logic [8:0]  sum_lo8;                       // Low byte sum.
    logic [4:0]  sum_lo4;                       // Low nibble sum.
    logic [15:0] opb;                           // Possibly inverted operand.
    logic        res_msb, res_c, res_hc, res_ov, res_zero;
    logic [15:0] status_v, control_v;           // Assembled read views.

    assign wr_st = i_reg_wr && (i_reg_addr == CSCR_STATUS_OFS);
    assign wr_cc = i_reg_wr && (i_reg_addr == CSCR_CONTROL_OFS);

    ////////////////////////////////////////////////////////////////////////
    // ALU flag derivation. Subtraction adds the complement with carry in
    // set, so carry and half carry come out as inverted borrows for free.
    assign opb     = i_alu_sub ? ~i_alu_b : i_alu_b;
    assign sum     = {1'b0, i_alu_a} + {1'b0, opb} + {16'h0, i_alu_sub};
    assign sum_lo8 = {1'b0, i_alu_a[7:0]} + {1'b0, opb[7:0]} + {8'h0, i_alu_sub};
    assign sum_lo4 = {1'b0, i_alu_a[3:0]} + {1'b0, opb[3:0]} + {4'h0, i_alu_sub};
    always_comb begin
        // Byte operations look at bit 7 and carry out of bit 7.
        if (i_alu_byte) begin
            res_msb  = sum[7];
            res_c    = sum_lo8[8];
            res_hc   = sum_lo4[4];
            res_ov   = (i_alu_a[7] == opb[7]) && (sum[7] != i_alu_a[7]);
            res_zero = (sum[7:0] == 8'h00);
        end else begin
            res_msb  = sum[15];
            res_c    = sum[16];
            res_hc   = sum_lo8[8];
            res_ov   = (i_alu_a[15] == opb[15]) && (sum[15] != i_alu_a[15]);
            res_zero = (sum[15:0] == 16'h0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Guard overflow flags: refreshed each time data passes the adder.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ovf_a_reg <= 1'b0;
            ovf_b_reg <= 1'b0;
        end else begin
            if (i_acc_upd_a) begin
                ovf_a_reg <= i_acc_ovf_a;
            end
            if (i_acc_upd_b) begin
                ovf_b_reg <= i_acc_ovf_b;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky saturation flags. Writes can only clear; a saturation event in
    // the same cycle as the clearing write wins, so no event is lost.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sat_a_reg <= 1'b0;
            sat_b_reg <= 1'b0;
        end else begin
            if (i_acc_sat_a) begin
                sat_a_reg <= 1'b1;
            end else if (wr_st && (!i_reg_wdata[ST_SA] || !i_reg_wdata[ST_SAB])) begin
                sat_a_reg <= 1'b0;
            end
            if (i_acc_sat_b) begin
                sat_b_reg <= 1'b1;
            end else if (wr_st && (!i_reg_wdata[ST_SB] || !i_reg_wdata[ST_SAB])) begin
                sat_b_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ALU flags. A datapath update takes priority over a software write.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hc_reg  <= 1'b0;
            neg_reg <= 1'b0;
            ov_reg  <= 1'b0;
            z_reg   <= 1'b0;
            c_reg   <= 1'b0;
        end else if (i_alu_upd) begin
            hc_reg  <= res_hc;
            neg_reg <= res_msb;
            ov_reg  <= res_ov;
            c_reg   <= res_c;
            if (!res_zero) begin
                z_reg <= 1'b0;
            end
        end else if (wr_st) begin
            hc_reg  <= i_reg_wdata[ST_HC];
            neg_reg <= i_reg_wdata[ST_NEG];
            ov_reg  <= i_reg_wdata[ST_OV];
            z_reg   <= i_reg_wdata[ST_Z];
            c_reg   <= i_reg_wdata[ST_C];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority level. The sequencer loads the full level on exception entry
    // and return; software reaches the low bits only while nesting is allowed.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prio_lo_reg  <= CSCR_PRIO_RST;
            prio_top_reg <= 1'b0;
        end else if (i_prio_wr) begin
            prio_lo_reg  <= i_prio_level[2:0];
            prio_top_reg <= i_prio_level[3];
        end else begin
            if (wr_st && !i_nesting_disable) begin
                prio_lo_reg <= i_reg_wdata[ST_PRH:ST_PRL];
            end
            if (wr_cc && !i_reg_wdata[CC_PRT]) begin
                prio_top_reg <= 1'b0;                                      // Clear-only bit.
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control modes, and the early exit pulse that never reads back.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_reg <= CSCR_CTRL_RST;
            edt_reg  <= 1'b0;
        end else begin
            edt_reg <= wr_cc && i_reg_wdata[CC_EDT] && i_do_active;
            if (wr_cc) begin
                mode_reg <= {i_reg_wdata[CC_ACC_A_CLIP_ENABLE:CC_WIDE], i_reg_wdata[CC_PSV:CC_IMUL]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state is sampled so the register view is glitch free.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            loop_reg  <= 1'b0;
            rpt_reg   <= 1'b0;
            depth_reg <= 3'h0;
        end else begin
            loop_reg  <= i_do_active;
            rpt_reg   <= i_rpt_active;
            depth_reg <= i_do_depth;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read views and read data, valid the cycle after the read strobe.
    always_comb begin
        status_v           = 16'h0000;
        status_v[ST_OA]    = ovf_a_reg;
        status_v[ST_OB]    = ovf_b_reg;
        status_v[ST_SA]    = sat_a_reg;
        status_v[ST_SB]    = sat_b_reg;
        status_v[ST_OAB]   = ovf_a_reg | ovf_b_reg;
        status_v[ST_SAB]   = sat_a_reg | sat_b_reg;
        status_v[ST_LOOP]  = loop_reg;
        status_v[ST_HC]    = hc_reg;
        status_v[ST_PRH:ST_PRL] = prio_lo_reg;
        status_v[ST_RPT]   = rpt_reg;
        status_v[ST_NEG]   = neg_reg;
        status_v[ST_OV]    = ov_reg;
        status_v[ST_Z]     = z_reg;
        status_v[ST_C]     = c_reg;
        control_v          = 16'h0000;
        control_v[CC_EDT]  = 1'b0;
        control_v[CC_DLH:CC_DLL] = depth_reg;
        control_v[CC_ACC_A_CLIP_ENABLE:CC_WIDE] = mode_reg[6:3];
        control_v[CC_PRT]  = prio_top_reg;
        control_v[CC_PSV:CC_IMUL] = mode_reg[2:0];
        control_v[CC_US]   = us_reg;
    end

    // Unsigned multiply select, stored apart from the packed modes.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            us_reg <= 1'b0;
        end else if (wr_cc) begin
            us_reg <= i_reg_wdata[CC_US];
        end
    end

    // Unmapped addresses read as zero.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= 16'h0000;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                CSCR_STATUS_OFS:  rdata_reg <= status_v;
                CSCR_CONTROL_OFS: rdata_reg <= control_v;
                default:          rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign o_reg_rdata             = rdata_reg;
    assign o_dsp_mul_unsigned      = us_reg;
    assign o_integer_mul_mode      = mode_reg[0];
    assign o_early_loop_exit       = edt_reg;
    assign o_acc_a_clip_enable     = mode_reg[6];
    assign o_acc_b_clip_enable     = mode_reg[5];
    assign o_store_clip_enable     = mode_reg[4];
    assign o_wide_clip_mode        = mode_reg[3];
    assign o_program_window_enable = mode_reg[2];
    assign o_rounding_select       = mode_reg[1];
    assign o_cpu_priority          = {prio_top_reg, prio_lo_reg};
    assign o_user_irq_disable      = prio_top_reg || (prio_lo_reg == CSCR_PRIO_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_sat_a_event;
        i_acc_sat_a;
    endsequence

    a_sat_a_sticks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        s_sat_a_event |=> sat_a_reg) else $error("sticky A not set");
    a_no_sw_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (!sat_a_reg && !i_acc_sat_a) |=> !sat_a_reg) else $error("sticky A set by software");
    a_sab_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (wr_st && !i_reg_wdata[ST_SAB] && !i_acc_sat_a && !i_acc_sat_b) |=> !(sat_a_reg || sat_b_reg))
        else $error("combined clear failed");
    a_ovf_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        i_acc_upd_a |=> ovf_a_reg == $past(i_acc_ovf_a)) else $error("overflow A wrong");
    a_prio_locked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_nesting_disable && !i_prio_wr) |=> $stable(prio_lo_reg)) else $error("priority changed");
    a_edt_reads_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == CSCR_CONTROL_OFS) |=> !o_reg_rdata[CC_EDT]) else $error("exit bit read one");
    a_zero_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_alu_upd && !res_zero) |=> !z_reg) else $error("zero flag kept");
    a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (prio_lo_reg == 3'h7) |-> o_user_irq_disable) else $error("irq not disabled");
    a_store_reset: assert property (@(posedge i_ref_clk)
        $rose(i_rst_b) |-> o_store_clip_enable) else $error("store enable reset wrong");
endmodule

// [testbench/cscr_core_model.sv]
/*
 * Behavioural model of the core datapath and sequencer that feed the flag block.
 * Assumes one bench process calls its tasks, all timed on the core clock.
 */
module cscr_core_model (
    // Core clock.
    input  wire logic        i_clk,
    // Accumulator events {upd_a, upd_b, ovf_a, ovf_b, sat_a, sat_b}.
    output logic      [5:0]  o_acc,
    // Sequencer state {do_active, rpt_active, do_depth}.
    output logic      [4:0]  o_seq,
    // Priority load {strobe, level}.
    output logic      [4:0]  o_prio,
    // ALU operation {upd, byte, sub, a, b}.
    output logic      [34:0] o_alu
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Quiet levels at time zero.
    initial begin
        o_acc = 6'h00;
        o_seq = 5'h00;
        o_prio = 5'h00;
        o_alu = 35'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle accumulator event; the overflow levels flip afterwards, since they are
    // only meaningful beside the update and a real datapath does not hold them.
    task automatic acc(input logic [5:0] v);
        @(posedge i_clk) o_acc <= v;
        @(posedge i_clk) o_acc <= {2'h0, ~v[3:2], 2'h0};
    endtask

    // One-cycle ALU result; operands turn to their inverse once the pulse is over.
    task automatic alu(input logic [33:0] v);
        @(posedge i_clk) o_alu <= {1'b1, v};
        @(posedge i_clk) o_alu <= {1'b0, ~v};
    endtask

    // Priority load pulse, as on exception entry.
    task automatic prio(input logic [3:0] lvl);
        @(posedge i_clk) o_prio <= {1'b1, lvl};
        @(posedge i_clk) o_prio <= {1'b0, ~lvl};
    endtask

    // New loop state; the block registers it one cycle, so let two edges pass.
    task automatic seq(input logic [4:0] v);
        @(posedge i_clk) o_seq <= v;
        repeat (2) @(posedge i_clk);
    endtask
endmodule

// [testbench/test_cscr_regs.sv]
/*
 * Self-checking bench for the status and core control register pair.
 * Assumes the register port answers reads one cycle later and the core model
 * stands in for the datapath and sequencer.
 */
module test_cscr_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import cscr_pkg::*;

    // ALU table row: operation beside expected {half carry, N, OV, Z, C}.
    typedef struct packed {logic byt; logic sub; logic [15:0] a; logic [15:0] b; logic [4:0] fl;} cscr_row_t;

    logic        i_ref_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [3:0]  i_reg_addr = 4'h0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic        i_nesting_disable = 1'b0;
    logic [15:0] o_reg_rdata;
    logic [5:0]  acc;
    logic [4:0]  seq;
    logic [4:0]  prio;
    logic [34:0] alu;
    logic [7:0]  modes;
    logic [3:0]  o_cpu_priority;
    logic        o_user_irq_disable;
    logic        o_early_loop_exit;
    int          n_errors = 0;
    int          total_checks = 0;
    int          n_exit = 0;
    // Zero-result row first, so the zero flag set by software must survive it.
    cscr_row_t   rows [5] = '{'{1'b0, 1'b1, 16'h0005, 16'h0005, 5'h13}, '{1'b0, 1'b0, 16'h7fff, 16'h0001, 5'h1c},
                              '{1'b0, 1'b1, 16'h0000, 16'h0001, 5'h08}, '{1'b1, 1'b0, 16'h000f, 16'h0001, 5'h10},
                              '{1'b1, 1'b0, 16'h00ff, 16'h0001, 5'h11}};

    always #2.5 i_ref_clk = ~i_ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    cscr_core_model model (.i_clk(i_ref_clk), .o_acc(acc), .o_seq(seq), .o_prio(prio), .o_alu(alu));

    cscr_regs DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_acc_upd_a(acc[5]), .i_acc_upd_b(acc[4]), .i_acc_ovf_a(acc[3]), .i_acc_ovf_b(acc[2]),
        .i_acc_sat_a(acc[1]), .i_acc_sat_b(acc[0]), .i_do_active(seq[4]), .i_rpt_active(seq[3]),
        .i_do_depth(seq[2:0]), .i_nesting_disable(i_nesting_disable), .i_prio_wr(prio[4]),
        .i_prio_level(prio[3:0]), .i_alu_upd(alu[34]), .i_alu_byte(alu[33]), .i_alu_sub(alu[32]),
        .i_alu_a(alu[31:16]), .i_alu_b(alu[15:0]), .o_dsp_mul_unsigned(modes[7]), .o_integer_mul_mode(modes[6]),
        .o_early_loop_exit(o_early_loop_exit), .o_acc_a_clip_enable(modes[5]), .o_acc_b_clip_enable(modes[4]),
        .o_store_clip_enable(modes[3]), .o_wide_clip_mode(modes[2]), .o_program_window_enable(modes[1]),
        .o_rounding_select(modes[0]), .o_cpu_priority(o_cpu_priority), .o_user_irq_disable(o_user_irq_disable));

    // Count early-exit pulses; a level stuck high would count more than once.
    always @(posedge i_ref_clk) if (o_early_loop_exit === 1'b1) n_exit++;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare with case equality so an unknown never matches.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask

    // Read strobe, then sample the data in the only cycle it stands.
    task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata & m, exp);
    endtask

    // Single exit point of the run.
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs under a hundred cycles.
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        n_errors++;
        stop_test;
    end

    // Main sequence: reset values, then the ALU table, then the hand-written cases.
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rc(CSCR_STATUS_OFS, 16'hffff, 16'h0000);
        rc(CSCR_CONTROL_OFS, 16'hffff, 16'h0020);
        chk({8'h00, modes}, 16'h0008);
        wr(CSCR_STATUS_OFS, 16'h0002);
        foreach (rows[i]) begin
            model.alu({rows[i].byt, rows[i].sub, rows[i].a, rows[i].b});
            rc(CSCR_STATUS_OFS, 16'h010f, {7'h0, rows[i].fl[4], 4'h0, rows[i].fl[3:0]});
        end
        // Every mode bit set; the top priority bit is clear-only and early exit reads zero.
        wr(CSCR_CONTROL_OFS, 16'h1fff);
        rc(CSCR_CONTROL_OFS, 16'hffff, 16'h10f7);
        chk({8'h00, modes}, 16'h00ff);
        // Loops running at depth three, then an early exit request.
        model.seq(5'b11011);
        rc(CSCR_STATUS_OFS, 16'h0210, 16'h0210);
        wr(CSCR_CONTROL_OFS, 16'h0800);
        rc(CSCR_CONTROL_OFS, 16'h0f00, 16'h0300);
        chk(16'(n_exit), 16'h0001);
        model.seq(5'b10111);
        rc(CSCR_CONTROL_OFS, 16'h0700, 16'h0700);
        model.seq(5'b00000);
        rc(CSCR_STATUS_OFS, 16'h0210, 16'h0000);
        // Overflow on A with saturation on B, then A clean and B overflowing.
        model.acc(6'b101001);
        rc(CSCR_STATUS_OFS, 16'hfc00, 16'h9c00);
        model.acc(6'b110100);
        rc(CSCR_STATUS_OFS, 16'hfc00, 16'h5c00);
        wr(CSCR_STATUS_OFS, 16'h3400);
        rc(CSCR_STATUS_OFS, 16'hfc00, 16'h5c00);
        wr(CSCR_STATUS_OFS, 16'h3000);
        rc(CSCR_STATUS_OFS, 16'hfc00, 16'h4800);
        // Priority codes from software, then a hardware load above seven.
        wr(CSCR_STATUS_OFS, 16'h00e0);
        rc(CSCR_STATUS_OFS, 16'h00e0, 16'h00e0);
        chk({11'h0, o_user_irq_disable, o_cpu_priority}, 16'h0017);
        wr(CSCR_STATUS_OFS, 16'h0060);
        rc(CSCR_STATUS_OFS, 16'h00e0, 16'h0060);
        chk({11'h0, o_user_irq_disable, o_cpu_priority}, 16'h0003);
        model.prio(4'hb);
        rc(CSCR_CONTROL_OFS, 16'h0008, 16'h0008);
        chk({11'h0, o_user_irq_disable, o_cpu_priority}, 16'h001b);
        // Low priority bits locked while nesting is disabled.
        @(posedge i_ref_clk) i_nesting_disable <= 1'b1;
        wr(CSCR_STATUS_OFS, 16'h0000);
        rc(CSCR_STATUS_OFS, 16'h00e0, 16'h0060);
        rc(4'h5, 16'hffff, 16'h0000);
        stop_test;
    end
endmodule
